//--- rtcc_calendar_regs.sv
/*
  Time of day and calendar counter bank with a minute and hour match.
  Assumes the serial interface logic on clk_i marks each access with
  access_active_i and gives single-cycle write strobes inside it; the 1 Hz
  tick arrives asynchronously from the oscillator.
*/
// What this block does
// - minutes: tens bits 6:4, units 3:0
// - 12-hour: meridiem bit 5, tens bit 4
// - format input selects 12/24 hour coding
// - days: tens bits 5:4, units 3:0
// - February 29 when year divisible by four
// - weekday 0-6 in bits 2:0
// - month BCD 1-12, bits 7:5 zero
// - year BCD 00-99 in bits 7:0
// - counters frozen during any access
// - one missed tick kept, applied after access
// - enabled match settings compared with time
// - minute setting: bit 7 disable, default 1
// - hour setting: bit 7 disable, bit 6 zero
// - seconds BCD, bit 7 integrity lost flag
// - match flag set on first full match
// - after clear, set only on new match
`timescale 1ns/1ns
`default_nettype none

module rtcc_calendar_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // oscillator tick and format
  input wire logic tick_1hz_i,
  input wire logic hour_12_mode_i,
  // register port
  input wire logic access_active_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // match flag
  input wire logic match_flag_clr_i,
  output logic match_flag_o,
  output logic match_o
);
  import rtcc_pkg::*;

  rtcc_regs_state_t s;
  rtcc_regs_state_t next_s;
  logic tick_pulse;
  logic do_inc;

  rtcc_tick_sync u_tick_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_i(tick_1hz_i),
    .tick_pulse_o(tick_pulse)
  );

  rtcc_match_cmp u_match_cmp (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .min_count_i(s.tm.min),
    .hour_count_i(s.tm.hour),
    .min_match_i(s.min_match),
    .hr_match_i(s.hr_match),
    .flag_clr_i(match_flag_clr_i),
    .match_o(match_o),
    .flag_o(match_flag_o)
  );

  // one step of the whole chain, seconds upward
  function automatic rtcc_time_t advance(input rtcc_time_t t, input logic fmt12);
    rtcc_time_t n;
    logic carry;
    logic [7:0] tmp;
    logic [4:0] h12;
    n = t;
    carry = 1'b0;
    // seconds, integrity flag left untouched
    if (t.sec[6:0] == RTCC_SEC_LAST) begin
      n.sec[6:0] = 7'h00;
      carry = 1'b1;
    end else begin
      tmp = rtcc_bcd_inc({1'b0, t.sec[6:0]});
      n.sec[6:0] = tmp[6:0];
    end
    // minutes
    if (carry) begin
      carry = 1'b0;
      if (t.min[6:0] == RTCC_MIN_LAST) begin
        n.min = 8'h00;
        carry = 1'b1;
      end else begin
        n.min = rtcc_bcd_inc(t.min);
      end
    end
    // hours in the selected format
    if (carry) begin
      carry = 1'b0;
      if (fmt12) begin
        h12 = t.hour[4:0];
        if (h12 == RTCC_HOUR12_ELEVEN) begin
          n.hour[4:0] = RTCC_HOUR12_TWELVE;
          n.hour[RTCC_MERIDIEM_BIT] = ~t.hour[RTCC_MERIDIEM_BIT];
          // 11 pm to 12 am starts a new day
          carry = t.hour[RTCC_MERIDIEM_BIT];
        end else if (h12 == RTCC_HOUR12_TWELVE) begin
          n.hour[4:0] = RTCC_HOUR12_ONE;
        end else begin
          tmp = rtcc_bcd_inc({3'b000, h12});
          n.hour[4:0] = tmp[4:0];
        end
      end else begin
        if (t.hour[5:0] == RTCC_HOUR24_LAST) begin
          n.hour = 8'h00;
          carry = 1'b1;
        end else begin
          n.hour = rtcc_bcd_inc(t.hour);
        end
      end
    end
    // day, weekday, month, year
    if (carry) begin
      carry = 1'b0;
      if (t.wday[2:0] == RTCC_WDAY_LAST) begin
        n.wday = 8'h00;
      end else begin
        n.wday = {5'b00000, t.wday[2:0] + 3'h1};
      end
      if (t.day[5:0] == rtcc_month_days(t.mon[4:0], t.year)) begin
        n.day = {2'b00, RTCC_DAY_FIRST};
        carry = 1'b1;
      end else begin
        n.day = rtcc_bcd_inc(t.day);
      end
    end
    if (carry) begin
      carry = 1'b0;
      if (t.mon[4:0] == RTCC_MON_LAST) begin
        n.mon = {3'b000, RTCC_MON_FIRST};
        carry = 1'b1;
      end else begin
        n.mon = rtcc_bcd_inc(t.mon);
      end
    end
    if (carry) begin
      if (t.year == RTCC_YEAR_LAST) begin
        n.year = 8'h00;
      end else begin
        n.year = rtcc_bcd_inc(t.year);
      end
    end
    return n;
  endfunction

  // read view; reserved bits already zero in storage
  function automatic logic [7:0] read_reg(input rtcc_regs_state_t r, input logic [7:0] a);
    if (a == RTCC_ADDR_SEC) begin
      return r.tm.sec;
    end else if (a == RTCC_ADDR_MIN) begin
      return r.tm.min;
    end else if (a == RTCC_ADDR_HOUR) begin
      return r.tm.hour;
    end else if (a == RTCC_ADDR_DAY) begin
      return r.tm.day;
    end else if (a == RTCC_ADDR_WDAY) begin
      return r.tm.wday;
    end else if (a == RTCC_ADDR_MON) begin
      return r.tm.mon;
    end else if (a == RTCC_ADDR_YEAR) begin
      return r.tm.year;
    end else if (a == RTCC_ADDR_MIN_MATCH) begin
      return r.min_match;
    end else if (a == RTCC_ADDR_HR_MATCH) begin
      return r.hr_match;
    end
    return 8'h00;
  endfunction

  always_comb begin
    next_s = s;
    do_inc = 1'b0;
    if (access_active_i) begin
      // frozen; a second tick in the same access is lost
      if (tick_pulse) begin
        next_s.pending = 1'b1;
      end
    end else if (s.pending) begin
      // held tick first; a tick landing now waits one more cycle
      do_inc = 1'b1;
      next_s.pending = tick_pulse;
    end else begin
      do_inc = tick_pulse;
    end
    if (do_inc) begin
      next_s.tm = advance(s.tm, hour_12_mode_i);
    end
    // a write outside an access still wins over a same-cycle increment
    if (reg_wr_i) begin
      if (reg_addr_i == RTCC_ADDR_SEC) begin
        next_s.tm.sec = reg_wdata_i & RTCC_MASK_SEC;
      end else if (reg_addr_i == RTCC_ADDR_MIN) begin
        next_s.tm.min = reg_wdata_i & RTCC_MASK_MIN;
      end else if (reg_addr_i == RTCC_ADDR_HOUR) begin
        next_s.tm.hour = reg_wdata_i & RTCC_MASK_HOUR;
      end else if (reg_addr_i == RTCC_ADDR_DAY) begin
        next_s.tm.day = reg_wdata_i & RTCC_MASK_DAY;
      end else if (reg_addr_i == RTCC_ADDR_WDAY) begin
        next_s.tm.wday = reg_wdata_i & RTCC_MASK_WDAY;
      end else if (reg_addr_i == RTCC_ADDR_MON) begin
        next_s.tm.mon = reg_wdata_i & RTCC_MASK_MON;
      end else if (reg_addr_i == RTCC_ADDR_YEAR) begin
        next_s.tm.year = reg_wdata_i & RTCC_MASK_YEAR;
      end else if (reg_addr_i == RTCC_ADDR_MIN_MATCH) begin
        next_s.min_match = reg_wdata_i & RTCC_MASK_MIN_MATCH;
      end else if (reg_addr_i == RTCC_ADDR_HR_MATCH) begin
        next_s.hr_match = reg_wdata_i & RTCC_MASK_HR_MATCH;
      end
    end
    // registered read, one cycle behind the address
    next_s.rd_data = read_reg(s, reg_addr_i);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // integrity lost flag comes up set
      s.tm.sec <= RTCC_RST_SEC;
      s.tm.min <= RTCC_RST_MIN;
      s.tm.hour <= RTCC_RST_HOUR;
      s.tm.day <= RTCC_RST_DAY;
      s.tm.wday <= RTCC_RST_WDAY;
      s.tm.mon <= RTCC_RST_MON;
      s.tm.year <= RTCC_RST_YEAR;
      // both match settings start disabled
      s.min_match <= RTCC_RST_MATCH;
      s.hr_match <= RTCC_RST_MATCH;
      s.pending <= 1'b0;
      s.rd_data <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rd_data;

endmodule

`default_nettype wire

//--- rtcc_calendar_regs_asserts.sv
/*
  Port checker for the time and calendar counter bank.
  Assumes the register port and the flag clear are clocked by clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcc_calendar_regs_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // tick and format
  input wire logic tick_1hz_i,
  input wire logic hour_12_mode_i,
  // register port
  input wire logic access_active_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // match flag
  input wire logic match_flag_clr_i,
  input wire logic match_flag_o,
  input wire logic match_o
);
  import rtcc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // read data right after reset still shows the reset zero
  logic [1:0] live;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) live <= 2'h0;
    else if (live != 2'h3) live <= live + 2'h1;
  end
  // a write one edge back still reaches the read view on the next edge
  sequence held_s;
    access_active_i && $past(access_active_i) && !reg_wr_i && !$past(reg_wr_i) &&
      $stable(reg_addr_i);
  endsequence
  sequence warm_s;
    live == 2'h3;
  endsequence
  property rsvd_p(logic [7:0] a, logic [7:0] keep);
    $past(reg_addr_i) == a |-> (reg_rdata_o & ~keep) == 8'h00;
  endproperty
  min_rsvd_a: assert property (rsvd_p(8'h03, 8'h7f)) else $error("minute bit 7 set");
  hour_rsvd_a: assert property (rsvd_p(8'h04, 8'h3f)) else $error("hour bits 7:6 set");
  day_rsvd_a: assert property (rsvd_p(8'h05, 8'h3f)) else $error("day bits 7:6 set");
  wday_rsvd_a: assert property (rsvd_p(8'h06, 8'h07)) else $error("weekday bits 7:3 set");
  mon_rsvd_a: assert property (rsvd_p(8'h07, 8'h1f)) else $error("month bits 7:5 set");
  hrm_rsvd_a: assert property (rsvd_p(8'h0a, 8'hbf)) else $error("hour match bit 6 set");
  unmapped_zero_a: assert property (($past(reg_addr_i) < 8'h02 || $past(reg_addr_i) > 8'h0a)
    |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  count_freeze_a: assert property (warm_s and held_s |=> $stable(reg_rdata_o))
    else $error("count moved during access");
  flag_set_a: assert property ($rose(match_o) |-> match_flag_o) else $error("flag not set");
  flag_cause_a: assert property ($rose(match_flag_o) |-> $rose(match_o))
    else $error("flag set without new match");
  flag_hold_a: assert property (match_flag_o && !match_flag_clr_i |=> match_flag_o)
    else $error("flag dropped without clear");
  flag_clear_a: assert property (match_flag_clr_i && match_o |=> !match_flag_o)
    else $error("flag kept after clear");
endmodule
bind rtcc_calendar_regs rtcc_calendar_regs_asserts i_chk (.clk_i, .arst_n_i, .tick_1hz_i,
  .hour_12_mode_i, .access_active_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .match_flag_clr_i, .match_flag_o, .match_o);
`default_nettype wire

//--- rtcc_host_model.sv
/*
  Host side register access model for the counter bank.
  Drives from the falling edge; assumes capture on the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcc_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic access_active_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  import rtcc_pkg::*;
  initial begin
    access_active_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  task open_acc();
    @(negedge clk_i) access_active_o = 1'b1;
  endtask
  task close_acc();
    @(negedge clk_i) access_active_o = 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_i) reg_wr_o = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i) reg_addr_o = a;
    @(negedge clk_i) d = reg_rdata_i;
  endtask
  // whole set in one short access, well inside one tick period
  task set_all(input rtcc_time_t t);
    open_acc();
    for (int i = 0; i < 7; i++) wr(RTCC_ADDR_SEC + 8'(i), t[55-8*i -: 8]);
    close_acc();
  endtask
  task read_all(output rtcc_time_t t);
    logic [7:0] d;
    open_acc();
    for (int i = 0; i < 7; i++) begin
      rd(RTCC_ADDR_SEC + 8'(i), d);
      t[55-8*i -: 8] = d;
    end
    close_acc();
  endtask
endmodule
`default_nettype wire

//--- rtcc_match_cmp.sv
/*
  Minute and hour match comparator with the sticky match flag. Assumes
  the hour setting uses the same hour format as the hour count.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcc_match_cmp (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // current time and settings
  input wire logic [7:0] min_count_i,
  input wire logic [7:0] hour_count_i,
  input wire logic [7:0] min_match_i,
  input wire logic [7:0] hr_match_i,
  // flag
  input wire logic flag_clr_i,
  output logic match_o,
  output logic flag_o
);
  import rtcc_pkg::*;

  rtcc_match_state_t s;
  rtcc_match_state_t next_s;
  logic min_on;
  logic hr_on;
  logic match_now;

  always_comb begin
    min_on = ~min_match_i[RTCC_MATCH_DISABLE_BIT];
    hr_on = ~hr_match_i[RTCC_MATCH_DISABLE_BIT];
    // disabled settings take no part; nothing enabled never matches
    match_now = (min_on | hr_on) &
                (!min_on || min_match_i[6:0] == min_count_i[6:0]) &
                (!hr_on || hr_match_i[5:0] == hour_count_i[5:0]);
    next_s = s;
    next_s.prev_match = match_now;
    if (flag_clr_i) begin
      next_s.flag = 1'b0;
    end
    // only a fresh match sets it, so a clear during a match sticks
    if (match_now && !s.prev_match) begin
      next_s.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign match_o = s.prev_match;
  assign flag_o = s.flag;

endmodule

`default_nettype wire

//--- rtcc_pkg.sv
/*
  Shared constants, state records and calendar arithmetic for the time and
  calendar counter bank. Assumes BCD coded register contents as loaded by
  the host; out-of-range values give undefined counting.
*/
package rtcc_pkg;

  // register locations
  localparam logic [7:0] RTCC_ADDR_SEC = 8'h02;
  localparam logic [7:0] RTCC_ADDR_MIN = 8'h03;
  localparam logic [7:0] RTCC_ADDR_HOUR = 8'h04;
  localparam logic [7:0] RTCC_ADDR_DAY = 8'h05;
  localparam logic [7:0] RTCC_ADDR_WDAY = 8'h06;
  localparam logic [7:0] RTCC_ADDR_MON = 8'h07;
  localparam logic [7:0] RTCC_ADDR_YEAR = 8'h08;
  localparam logic [7:0] RTCC_ADDR_MIN_MATCH = 8'h09;
  localparam logic [7:0] RTCC_ADDR_HR_MATCH = 8'h0a;

  // implemented bits of each register; the rest read zero
  localparam logic [7:0] RTCC_MASK_SEC = 8'hff;
  localparam logic [7:0] RTCC_MASK_MIN = 8'h7f;
  localparam logic [7:0] RTCC_MASK_HOUR = 8'h3f;
  localparam logic [7:0] RTCC_MASK_DAY = 8'h3f;
  localparam logic [7:0] RTCC_MASK_WDAY = 8'h07;
  localparam logic [7:0] RTCC_MASK_MON = 8'h1f;
  localparam logic [7:0] RTCC_MASK_YEAR = 8'hff;
  localparam logic [7:0] RTCC_MASK_MIN_MATCH = 8'hff;
  localparam logic [7:0] RTCC_MASK_HR_MATCH = 8'hbf;

  // field positions
  localparam int RTCC_INTEGRITY_BIT = 7;
  localparam int RTCC_MATCH_DISABLE_BIT = 7;
  localparam int RTCC_MERIDIEM_BIT = 5;

  // reset values
  localparam logic [7:0] RTCC_RST_SEC = 8'h80;
  localparam logic [7:0] RTCC_RST_MIN = 8'h00;
  localparam logic [7:0] RTCC_RST_HOUR = 8'h00;
  localparam logic [7:0] RTCC_RST_DAY = 8'h01;
  localparam logic [7:0] RTCC_RST_WDAY = 8'h00;
  localparam logic [7:0] RTCC_RST_MON = 8'h01;
  localparam logic [7:0] RTCC_RST_YEAR = 8'h00;
  localparam logic [7:0] RTCC_RST_MATCH = 8'h80;

  // rollover points
  localparam logic [6:0] RTCC_SEC_LAST = 7'h59;
  localparam logic [6:0] RTCC_MIN_LAST = 7'h59;
  localparam logic [5:0] RTCC_HOUR24_LAST = 6'h23;
  localparam logic [4:0] RTCC_HOUR12_ELEVEN = 5'h11;
  localparam logic [4:0] RTCC_HOUR12_TWELVE = 5'h12;
  localparam logic [4:0] RTCC_HOUR12_ONE = 5'h01;
  localparam logic [2:0] RTCC_WDAY_LAST = 3'h6;
  localparam logic [4:0] RTCC_MON_LAST = 5'h12;
  localparam logic [7:0] RTCC_YEAR_LAST = 8'h99;
  localparam logic [5:0] RTCC_DAY_FIRST = 6'h01;
  localparam logic [4:0] RTCC_MON_FIRST = 5'h01;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] mon;
    logic [7:0] year;
  } rtcc_time_t;

  typedef struct packed {
    rtcc_time_t tm;
    logic [7:0] min_match;
    logic [7:0] hr_match;
    logic pending;
    logic [7:0] rd_data;
  } rtcc_regs_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } rtcc_sync_state_t;

  typedef struct packed {
    logic prev_match;
    logic flag;
  } rtcc_match_state_t;

  // next BCD value, units 9 wraps into the tens digit
  function automatic logic [7:0] rtcc_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // year divisible by four, year 00 included
  function automatic logic rtcc_is_leap(input logic [7:0] y);
    logic [6:0] bin;
    bin = 7'(y[7:4]) * 7'd10 + 7'(y[3:0]);
    return bin[1:0] == 2'b00;
  endfunction

  function automatic logic [5:0] rtcc_month_days(input logic [4:0] m, input logic [7:0] y);
    case (m)
      5'h02: return rtcc_is_leap(y) ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default: return 6'h31;
    endcase
  endfunction

endpackage

//--- rtcc_tick_sync.sv
/*
  Brings the 1 Hz tick from the oscillator domain onto clk_i and turns
  each rising edge into a one-cycle pulse. Assumes the tick stays high and
  low for several clk_i periods each.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcc_tick_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // tick in and pulse out
  input wire logic tick_i,
  output logic tick_pulse_o
);
  import rtcc_pkg::*;

  rtcc_sync_state_t s;
  rtcc_sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = tick_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // a change counts only once two later stages agree
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_pulse_o = next_s.level & ~s.level;

endmodule

`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the counter bank with the host model.
  Ticks are sped up; each counts after the tick synchroniser settles.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rtcc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic tick_1hz_i = 1'b0;
  logic hour_12_mode_i = 1'b0;
  logic match_flag_clr_i = 1'b0;
  logic access_active, reg_wr, match_flag, match;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int err_total = 0;
  int total_checks = 0;
  initial forever #4 clk_i = ~clk_i;
  rtcc_calendar_regs i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .tick_1hz_i(tick_1hz_i),
    .hour_12_mode_i(hour_12_mode_i), .access_active_i(access_active), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .match_flag_clr_i(match_flag_clr_i), .match_flag_o(match_flag), .match_o(match));
  rtcc_host_model i_host (.clk_i(clk_i), .access_active_o(access_active), .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick();
    @(negedge clk_i) tick_1hz_i = 1'b1;
    repeat (8) @(negedge clk_i);
    tick_1hz_i = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask
  task t_reset();
    rtcc_time_t t;
    logic [7:0] d;
    i_host.read_all(t);
    chk(64'(t), 64'h80000001000100);
    i_host.rd(RTCC_ADDR_MIN_MATCH, d);
    chk(64'(d), 64'h80);
    i_host.rd(RTCC_ADDR_HR_MATCH, d);
    chk(64'(d), 64'h80);
  endtask
  task automatic t_masks();
    logic [7:0] ad [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b};
    logic [7:0] ex [8] = '{8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h1f, 8'hff, 8'hbf, 8'h00};
    logic [7:0] d;
    i_host.open_acc();
    for (int i = 0; i < 8; i++) begin
      i_host.wr(ad[i], 8'hff);
      i_host.rd(ad[i], d);
      chk(64'(d), 64'(ex[i]));
    end
    i_host.wr(RTCC_ADDR_HR_MATCH, 8'h80);
    i_host.close_acc();
  endtask
  task t_roll();
    rtcc_time_t t;
    i_host.set_all({8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
    tick();
    i_host.read_all(t);
    chk(64'(t), 64'h00000001000100);
  endtask
  task automatic t_leap();
    logic [7:0] yr [3] = '{8'h00, 8'h04, 8'h01};
    rtcc_time_t t;
    for (int i = 0; i < 3; i++) begin
      i_host.set_all({8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h02, yr[i]});
      tick();
      i_host.read_all(t);
      chk(64'({t.day, t.mon}), (i < 2) ? 64'h2902 : 64'h0103);
    end
  endtask
  task automatic t_12h();
    logic [7:0] hin [3] = '{8'h11, 8'h32, 8'h31};
    logic [15:0] ex [3] = '{16'h3215, 16'h2115, 16'h1216};
    rtcc_time_t t;
    @(negedge clk_i) hour_12_mode_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      i_host.set_all({8'h59, 8'h59, hin[i], 8'h15, 8'h02, 8'h05, 8'h20});
      tick();
      i_host.read_all(t);
      chk(64'({t.hour, t.day}), 64'(ex[i]));
    end
    @(negedge clk_i) hour_12_mode_i = 1'b0;
  endtask
  // two ticks inside one access: only one may survive
  task t_freeze();
    logic [7:0] d;
    i_host.set_all({8'h10, 8'h00, 8'h08, 8'h15, 8'h02, 8'h05, 8'h20});
    i_host.open_acc();
    i_host.rd(RTCC_ADDR_SEC, d);
    tick();
    tick();
    i_host.rd(RTCC_ADDR_SEC, d);
    chk(64'(d), 64'h10);
    i_host.close_acc();
    repeat (4) @(negedge clk_i);
    i_host.open_acc();
    i_host.rd(RTCC_ADDR_SEC, d);
    i_host.close_acc();
    chk(64'(d), 64'h11);
  endtask
  task t_match();
    i_host.set_all({8'h59, 8'h04, 8'h07, 8'h15, 8'h02, 8'h05, 8'h20});
    i_host.open_acc();
    i_host.wr(RTCC_ADDR_MIN_MATCH, 8'h05);
    i_host.wr(RTCC_ADDR_HR_MATCH, 8'h07);
    i_host.close_acc();
    chk(64'({match, match_flag}), 64'h0);
    tick();
    chk(64'({match, match_flag}), 64'h3);
    @(negedge clk_i) match_flag_clr_i = 1'b1;
    @(negedge clk_i) match_flag_clr_i = 1'b0;
    chk(64'(match_flag), 64'h0);
    i_host.wr(RTCC_ADDR_HR_MATCH, 8'h08);
    repeat (2) @(negedge clk_i);
    chk(64'({match, match_flag}), 64'h0);
    i_host.wr(RTCC_ADDR_HR_MATCH, 8'h88);
    repeat (2) @(negedge clk_i);
    chk(64'({match, match_flag}), 64'h3);
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    t_reset();
    t_masks();
    t_roll();
    t_leap();
    t_12h();
    t_freeze();
    t_match();
    final_report();
  end
  // whole run is a few hundred cycles
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
